// File: logic/pbm_pkg.sv
// Operation
// - direction 1 makes a pin an input; pull-up on while pull-up disable bit clear
// - an enabled LCD segment owns its pin; bit 0 is segment 30, bit 5 segment 29
// - bits 0-3 set as inputs feed external interrupt inputs 0-3
// - bit 3 output: compare/PWM drive beats latch; as input it is the capture input
// - PWM channel A on bit 3 may float the pin during a shutdown event
// - bit 0 supplies the PWM fault input whatever its direction, except while segment 30 owns it
// - bit 5 supplies timer3 clock and timer1 gate whatever its direction, except while segment 29 owns it
// - in programming mode bit 6 is serial clock, bit 7 serial data, direction ignored
// - direction-independent functions read the pin or set direction themselves
// - input pins 7-4 mismatching the last-read value OR into the change flag
// - a port read ends mismatch; flag keeps setting until then, clearable one cycle later
// - pull-up off on output pins; all pull-ups off after reset
package pbm_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, low address byte)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PIN_VALUE = 8'h00;
  localparam logic [7:0] ADDR_OUT_LATCH = 8'h04;
  localparam logic [7:0] ADDR_DIRECTION = 8'h08;
  localparam logic [7:0] ADDR_ICTL0 = 8'h0C;
  localparam logic [7:0] ADDR_ICTL_EDGE = 8'h10;
  localparam logic [7:0] ADDR_ICTL_EXT = 8'h14;
  localparam logic [7:0] ADDR_SEG_8_15 = 8'h18;
  localparam logic [7:0] ADDR_SEG_24_31 = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h20;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h24;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h28;
  localparam logic [7:0] ADDR_ALT_CTL = 8'h2C;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_LATCH = 8'h00;
  localparam logic [7:0] RST_DIRECTION = 8'hFF;
  localparam logic [7:0] RST_ICTL = 8'h00;
  localparam logic [7:0] RST_ICTL_EDGE = 8'hFF;
  localparam logic [7:0] RST_SEG = 8'h00;
  localparam logic [4:0] RST_IRQ = 5'h00;
  localparam logic [7:0] RST_ALT_CTL = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PIN_CAPCOMP = 3;
  localparam int PIN_FAULT = 0;
  localparam int PIN_TIMER = 5;
  localparam int PIN_PROG_CLK = 6;
  localparam int PIN_PROG_DAT = 7;
  localparam int PIN_EDGE1 = 2;
  localparam int PIN_EDGE2 = 3;
  localparam int LCD_SEG_OUT_30_BIT = 6;
  localparam int LCD_SEG_OUT_29_BIT = 5;
  localparam int PULLUP_DIS_BIT = 7;
  localparam int EDGE_SEL_TOP = 6;
  localparam int ICTL0_CHG_FLAG = 0;
  localparam int ICTL0_EXT0_FLAG = 1;
  localparam int ICTL0_CHG_EN = 3;
  localparam int ICTL0_EXT0_EN = 4;
  localparam int ICTL_EXT_EN_LO = 3;
  localparam int ALT_TRI_SHDN = 0;
  localparam int ST_CHG = 0;
  localparam int ST_EXT_LO = 1;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int TCY_NS = 100;
  localparam int CHG_HOLD_CYC = (TCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'h2;

  // ----------------------------------------------------------------
  // alternate function carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic lcd_seg_out_30;
    logic lcd_seg_out_29;
    logic [3:0] lcd_seg_out_8_11;
    logic capcomp_out_en;
    logic capcomp_out;
    logic pwm2_chan_a_sel;
    logic pwm2_chan_a_out;
    logic pwm_shutdown;
    logic prog_mode;
    logic prog_serial_dat_out;
    logic prog_serial_dat_oe;
  } pbm_alt_in_t;

  typedef struct packed {
    logic [3:0] ext_irq_in;
    logic [3:0] change_irq_in;
    logic pwm_fault_in;
    logic capcomp_capture_in;
    logic timer3_clk_in;
    logic timer1_gate_in;
    logic edge_in_1;
    logic edge_in_2;
    logic prog_serial_clk;
    logic prog_serial_dat;
  } pbm_alt_out_t;

endpackage : pbm_pkg

// File: logic/pbm_pin_cell.sv
`timescale 1ns/1ps
module pbm_pin_cell (
  input wire logic dir,
  input wire logic lat,
  input wire logic seg_en,
  input wire logic seg_val,
  input wire logic alt_en,
  input wire logic alt_val,
  input wire logic alt_tri,
  input wire logic force_en,
  input wire logic force_oe,
  input wire logic force_val,
  input wire logic pullup_disable_n,
  output logic out,
  output logic oe,
  output logic pu,
  output logic in_en
);

  // ----------------------------------------------------------------
  // pin ownership, highest priority first
  // ----------------------------------------------------------------
  always_comb begin
    out = 1'b0;
    oe = 1'b0;
    pu = 1'b0;
    in_en = 1'b1;
    if (seg_en) begin
      // segment drive cuts every digital path
      out = seg_val;
      oe = 1'b1;
      in_en = 1'b0;
    end else if (force_en) begin
      out = force_val;
      oe = force_oe;
    end else if (!dir) begin
      if (alt_en) begin
        out = alt_val;
        oe = ~alt_tri;
      end else begin
        out = lat;
        oe = 1'b1;
      end
    end else begin
      pu = ~pullup_disable_n;
    end
  end

endmodule : pbm_pin_cell

// File: logic/pbm_port.sv
// Chosen here: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
module pbm_port #(
  parameter int NUM_PINS = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output logic [7:0] pin_pullup_en,
  input wire pbm_pkg::pbm_alt_in_t alt_in,
  output pbm_pkg::pbm_alt_out_t alt_out,
  output logic irq
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  // pin roles are fixed to bit positions, so only an 8-pin port works
  if (NUM_PINS != 8) begin : g_bad_width
    $error("pbm_port supports exactly 8 pins");
  end

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [7:0] lat_r;
  logic [7:0] dir_r;
  logic [7:0] ictl0_r;
  logic [7:0] ictl_edge_r;
  logic [7:0] ictl_ext_r;
  logic [7:0] seg_lo_r;
  logic [7:0] seg_hi_r;
  logic [7:0] alt_ctl_r;
  logic [4:0] status_r;
  logic [4:0] irq_en_r;
  logic [3:0] old_r;
  logic [3:0] ext_prev_r;
  logic [1:0] guard_r;
  logic [7:0] addr_r;
  logic wr_r;
  logic act_r;
  logic [31:0] hrdata_r;
  logic [7:0] pin_out_r;
  logic [7:0] pin_oe_r;
  logic [7:0] pin_pu_r;
  pbm_pkg::pbm_alt_out_t alt_out_r;

  logic take;
  logic wr_en;
  logic [7:0] wdat;
  logic port_touch;
  logic [7:0] rd_mux;
  logic [7:0] seg_en;
  logic [7:0] seg_val;
  logic [7:0] alt_en;
  logic [7:0] alt_val;
  logic [7:0] alt_tri;
  logic [7:0] force_en;
  logic [7:0] force_oe;
  logic [7:0] force_val;
  logic [7:0] cell_out;
  logic [7:0] cell_oe;
  logic [7:0] cell_pu;
  logic [7:0] cell_in_en;
  logic [7:0] pin_vis;
  logic [3:0] chg_in;
  logic mismatch;
  logic [3:0] ext_now;
  logic [3:0] ext_edge;
  logic [4:0] ev_set;
  logic [4:0] ev_clr;
  logic [4:0] src_en;
  logic pullup_disable_n;
  logic arm_r;

  // ----------------------------------------------------------------
  // bus slave: one-cycle address phase, zero-wait data phase
  // ----------------------------------------------------------------
  assign take = hsel & hready & (htrans[1] == pbm_pkg::HTRANS_NONSEQ_BIT[1]);
  assign wr_en = act_r & wr_r;
  assign wdat = hwdata[7:0];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_r <= 8'h00;
      wr_r <= 1'b0;
      act_r <= 1'b0;
    end else begin
      act_r <= take;
      if (take) begin
        addr_r <= haddr[7:0];
        wr_r <= hwrite;
      end
    end
  end

  // read data is captured at the address phase; the data phase shows it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      hrdata_r <= {24'h00_0000, rd_mux};
    end
  end

  always_comb begin
    case (haddr[7:0])
      pbm_pkg::ADDR_PIN_VALUE: rd_mux = pin_vis;
      pbm_pkg::ADDR_OUT_LATCH: rd_mux = lat_r;
      pbm_pkg::ADDR_DIRECTION: rd_mux = dir_r;
      pbm_pkg::ADDR_ICTL0: rd_mux = {ictl0_r[7:2], status_r[pbm_pkg::ST_EXT_LO],
                                     status_r[pbm_pkg::ST_CHG]};
      pbm_pkg::ADDR_ICTL_EDGE: rd_mux = ictl_edge_r;
      pbm_pkg::ADDR_ICTL_EXT: rd_mux = {ictl_ext_r[7:3], status_r[4:2]};
      pbm_pkg::ADDR_SEG_8_15: rd_mux = seg_lo_r;
      pbm_pkg::ADDR_SEG_24_31: rd_mux = seg_hi_r;
      pbm_pkg::ADDR_IRQ_STATUS: rd_mux = {3'h0, status_r};
      pbm_pkg::ADDR_IRQ_ENABLE: rd_mux = {3'h0, irq_en_r};
      pbm_pkg::ADDR_ALT_CTL: rd_mux = alt_ctl_r;
      default: rd_mux = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lat_r <= pbm_pkg::RST_LATCH;
    end else if (wr_en && (addr_r == pbm_pkg::ADDR_PIN_VALUE ||
                           addr_r == pbm_pkg::ADDR_OUT_LATCH)) begin
      lat_r <= wdat;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dir_r <= pbm_pkg::RST_DIRECTION;
      ictl0_r <= pbm_pkg::RST_ICTL;
      ictl_edge_r <= pbm_pkg::RST_ICTL_EDGE;
      ictl_ext_r <= pbm_pkg::RST_ICTL;
      seg_lo_r <= pbm_pkg::RST_SEG;
      seg_hi_r <= pbm_pkg::RST_SEG;
      irq_en_r <= pbm_pkg::RST_IRQ;
      alt_ctl_r <= pbm_pkg::RST_ALT_CTL;
    end else if (wr_en) begin
      case (addr_r)
        pbm_pkg::ADDR_DIRECTION: dir_r <= wdat;
        pbm_pkg::ADDR_ICTL0: ictl0_r <= wdat;
        pbm_pkg::ADDR_ICTL_EDGE: ictl_edge_r <= wdat;
        pbm_pkg::ADDR_ICTL_EXT: ictl_ext_r <= wdat;
        pbm_pkg::ADDR_SEG_8_15: seg_lo_r <= wdat;
        pbm_pkg::ADDR_SEG_24_31: seg_hi_r <= wdat;
        pbm_pkg::ADDR_IRQ_ENABLE: irq_en_r <= wdat[4:0];
        pbm_pkg::ADDR_ALT_CTL: alt_ctl_r <= wdat;
        default: ;
      endcase
    end
  end

  assign pullup_disable_n = ictl_edge_r[pbm_pkg::PULLUP_DIS_BIT];

  // ----------------------------------------------------------------
  // per-pin alternate function selection
  // ----------------------------------------------------------------
  always_comb begin
    seg_en = 8'h00;
    seg_val = 8'h00;
    alt_en = 8'h00;
    alt_val = 8'h00;
    alt_tri = 8'h00;
    force_en = 8'h00;
    force_oe = 8'h00;
    force_val = 8'h00;
    seg_en[0] = seg_hi_r[pbm_pkg::LCD_SEG_OUT_30_BIT];
    seg_val[0] = alt_in.lcd_seg_out_30;
    seg_en[4:1] = seg_lo_r[3:0];
    seg_val[4:1] = alt_in.lcd_seg_out_8_11;
    seg_en[5] = seg_hi_r[pbm_pkg::LCD_SEG_OUT_29_BIT];
    seg_val[5] = alt_in.lcd_seg_out_29;
    alt_en[pbm_pkg::PIN_CAPCOMP] = alt_in.capcomp_out_en;
    alt_val[pbm_pkg::PIN_CAPCOMP] = alt_in.pwm2_chan_a_sel ? alt_in.pwm2_chan_a_out
                                                           : alt_in.capcomp_out;
    alt_tri[pbm_pkg::PIN_CAPCOMP] = alt_in.pwm2_chan_a_sel & alt_in.pwm_shutdown &
                                    alt_ctl_r[pbm_pkg::ALT_TRI_SHDN];
    // programming mode ignores the direction register on both pins
    force_en[pbm_pkg::PIN_PROG_CLK] = alt_in.prog_mode;
    force_en[pbm_pkg::PIN_PROG_DAT] = alt_in.prog_mode;
    force_oe[pbm_pkg::PIN_PROG_DAT] = alt_in.prog_serial_dat_oe;
    force_val[pbm_pkg::PIN_PROG_DAT] = alt_in.prog_serial_dat_out;
  end

  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    pbm_pin_cell u_cell (
      .dir(dir_r[i]),
      .lat(lat_r[i]),
      .seg_en(seg_en[i]),
      .seg_val(seg_val[i]),
      .alt_en(alt_en[i]),
      .alt_val(alt_val[i]),
      .alt_tri(alt_tri[i]),
      .force_en(force_en[i]),
      .force_oe(force_oe[i]),
      .force_val(force_val[i]),
      .pullup_disable_n(pullup_disable_n),
      .out(cell_out[i]),
      .oe(cell_oe[i]),
      .pu(cell_pu[i]),
      .in_en(cell_in_en[i])
    );
  end

  // segment-owned pins read back as zero
  assign pin_vis = pin_in & cell_in_en;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_out_r <= 8'h00;
      pin_oe_r <= 8'h00;
      pin_pu_r <= 8'h00;
    end else begin
      pin_out_r <= cell_out;
      pin_oe_r <= cell_oe;
      pin_pu_r <= cell_pu;
    end
  end

  assign pin_out = pin_out_r;
  assign pin_oe = pin_oe_r;
  assign pin_pullup_en = pin_pu_r;

  // ----------------------------------------------------------------
  // inputs handed to peripherals
  // ----------------------------------------------------------------
  assign ext_now = pin_vis[3:0] & dir_r[3:0];
  assign chg_in = pin_vis[7:4] & dir_r[7:4];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alt_out_r <= '0;
    end else begin
      alt_out_r.ext_irq_in <= ext_now;
      alt_out_r.change_irq_in <= chg_in;
      alt_out_r.pwm_fault_in <= pin_vis[pbm_pkg::PIN_FAULT];
      alt_out_r.capcomp_capture_in <= pin_vis[pbm_pkg::PIN_CAPCOMP] &
                                      dir_r[pbm_pkg::PIN_CAPCOMP];
      alt_out_r.timer3_clk_in <= pin_vis[pbm_pkg::PIN_TIMER];
      alt_out_r.timer1_gate_in <= pin_vis[pbm_pkg::PIN_TIMER];
      alt_out_r.edge_in_1 <= pin_vis[pbm_pkg::PIN_EDGE1];
      alt_out_r.edge_in_2 <= pin_vis[pbm_pkg::PIN_EDGE2];
      alt_out_r.prog_serial_clk <= pin_in[pbm_pkg::PIN_PROG_CLK] & alt_in.prog_mode;
      alt_out_r.prog_serial_dat <= pin_in[pbm_pkg::PIN_PROG_DAT] & alt_in.prog_mode;
    end
  end

  assign alt_out = alt_out_r;

  // ----------------------------------------------------------------
  // interrupt-on-change
  // ----------------------------------------------------------------
  // any access to the pin value register re-arms the compare
  assign port_touch = take && (haddr[7:0] == pbm_pkg::ADDR_PIN_VALUE);
  // output and segment pins drop out of the compare; a change either way counts
  assign mismatch = arm_r & (|((pin_vis[7:4] ^ old_r) & dir_r[7:4] &
                              cell_in_en[7:4]));

  // the first cycle after reset only loads the compare state, so no false event follows reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      arm_r <= 1'b0;
    end else begin
      arm_r <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      old_r <= 4'h0;
    end else if (port_touch || !arm_r) begin
      old_r <= pin_vis[7:4];
    end
  end

  // keeps the flag from clearing until the mismatch has had a cycle to end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      guard_r <= 2'h0;
    end else if (port_touch) begin
      guard_r <= 2'(pbm_pkg::CHG_HOLD_CYC);
    end else if (guard_r != 2'h0) begin
      guard_r <= guard_r - 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // external interrupt edges
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_prev_r <= 4'h0;
    end else begin
      ext_prev_r <= ext_now;
    end
  end

  for (genvar j = 0; j < 4; j++) begin : g_edge
    // edge select bit high picks the rising edge
    assign ext_edge[j] = arm_r & (ictl_edge_r[pbm_pkg::EDGE_SEL_TOP - j] ?
                         (ext_now[j] & ~ext_prev_r[j]) : (~ext_now[j] & ext_prev_r[j]));
  end

  // ----------------------------------------------------------------
  // sticky status, clear and interrupt output
  // ----------------------------------------------------------------
  assign ev_set = {ext_edge, mismatch};

  always_comb begin
    ev_clr = 5'h00;
    if (wr_en && addr_r == pbm_pkg::ADDR_IRQ_CLEAR) begin
      ev_clr = wdat[4:0];
    end
    if (wr_en && addr_r == pbm_pkg::ADDR_ICTL0) begin
      ev_clr[pbm_pkg::ST_CHG] = ev_clr[pbm_pkg::ST_CHG] | ~wdat[pbm_pkg::ICTL0_CHG_FLAG];
      ev_clr[pbm_pkg::ST_EXT_LO] = ev_clr[pbm_pkg::ST_EXT_LO] |
                                   ~wdat[pbm_pkg::ICTL0_EXT0_FLAG];
    end
    if (wr_en && addr_r == pbm_pkg::ADDR_ICTL_EXT) begin
      ev_clr[4:2] = ev_clr[4:2] | ~wdat[2:0];
    end
    // change flag cannot clear inside the hold window after a port access
    if (guard_r != 2'h0 || port_touch) begin
      ev_clr[pbm_pkg::ST_CHG] = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_r <= pbm_pkg::RST_IRQ;
    end else begin
      // a new event wins over a clear in the same cycle
      status_r <= (status_r & ~ev_clr) | ev_set;
    end
  end

  assign src_en = {ictl_ext_r[pbm_pkg::ICTL_EXT_EN_LO +: 3],
                   ictl0_r[pbm_pkg::ICTL0_EXT0_EN], ictl0_r[pbm_pkg::ICTL0_CHG_EN]};
  assign irq = |(status_r & irq_en_r & src_en);

endmodule : pbm_port

// File: tb/pbm_port_sva.sv
`timescale 1ns/1ps
module pbm_port_sva #(
  parameter int NUM_PINS = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic [7:0] pin_in,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pullup_en,
  input wire pbm_pkg::pbm_alt_in_t alt_in,
  input wire pbm_pkg::pbm_alt_out_t alt_out
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ------
  // bus
  // ------
  property p_okay;
    hreadyout && !hresp;
  endproperty
  a_okay: assert property (p_okay) else $error("bus not ready or not okay");
  property p_rd_hi;
    hrdata[31:8] == 24'h0;
  endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("read data upper bits set");
  // ------
  // pins
  // ------
  property p_pullup;
    (pin_pullup_en & pin_oe) == 8'h00;
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up on driven pin");
  // a segment takes the pin one cycle before its enable shows, hence both samples
  property p_fault;
    $past(hresetn) && !$past(pin_oe[0]) && !pin_oe[0] |->
      alt_out.pwm_fault_in == $past(pin_in[0]);
  endproperty
  a_fault: assert property (p_fault) else $error("fault input not pin 0");
  // both timer inputs come from the same pin, so they never differ
  property p_timer;
    $past(hresetn) && !$past(pin_oe[5]) && !pin_oe[5] |->
      alt_out.timer3_clk_in == $past(pin_in[5]) && alt_out.timer1_gate_in == $past(pin_in[5]);
  endproperty
  a_timer: assert property (p_timer) else $error("timer inputs not pin 5");
  property p_ext;
    $past(hresetn) && $past(pin_oe[3:0]) == 4'h0 && pin_oe[3:0] == 4'h0 |->
      alt_out.ext_irq_in == $past(pin_in[3:0]);
  endproperty
  a_ext: assert property (p_ext) else $error("ext irq inputs not pins 3-0");
  property p_prog;
    $past(hresetn) && $past(alt_in.prog_mode) |-> !pin_oe[6] &&
      pin_oe[7] == $past(alt_in.prog_serial_dat_oe) &&
      (!pin_oe[7] || pin_out[7] == $past(alt_in.prog_serial_dat_out));
  endproperty
  a_prog: assert property (p_prog) else $error("programming pins wrong");
  property p_capcomp;
    $past(hresetn) && $past(alt_in.capcomp_out_en) && !$past(alt_in.pwm2_chan_a_sel) &&
      $past(pin_oe[3]) && pin_oe[3] |-> pin_out[3] == $past(alt_in.capcomp_out);
  endproperty
  a_capcomp: assert property (p_capcomp) else $error("compare output lost");
endmodule : pbm_port_sva

// File: tb/pbm_ext_model.sv
`timescale 1ns/1ps
module pbm_ext_model (
  input wire logic hclk,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pullup_en,
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  output logic [7:0] pin_lvl
);
  logic [7:0] float_r = 8'h00;
  // a floating pin wanders, so no stale level can be trusted
  always @(posedge hclk) begin
    float_r <= ~float_r;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_lvl[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
        pin_pullup_en[i] ? 1'b1 : float_r[i];
    end
  end
endmodule : pbm_ext_model

// File: tb/test_port_b_pin_mux.sv
`timescale 1ns/1ps
module test_port_b_pin_mux;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, irq;
  logic [31:0] hrdata, rv;
  logic [7:0] pin_lvl, pin_out, pin_oe, pin_pullup_en;
  logic [7:0] ext_val = 8'h00;
  logic [7:0] ext_en = 8'hFF;
  logic [7:0] d, l, v, en, s, m_edge;
  logic [15:0] rtab [11] = '{16'h0400, 16'h08FF, 16'h0C00, 16'h10FF, 16'h1400, 16'h1800,
    16'h1C00, 16'h2000, 16'h2800, 16'h2C00, 16'h3000};
  pbm_pkg::pbm_alt_in_t alt_in = '0;
  pbm_pkg::pbm_alt_out_t alt_out;
  int n_errors = 0;
  int total_checks = 0;
  int k;

  always #50 hclk = ~hclk;

  pbm_port #(.NUM_PINS(8)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .pin_in(pin_lvl), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en),
    .alt_in(alt_in), .alt_out(alt_out), .irq(irq));
  pbm_ext_model i_ext (.hclk(hclk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup_en(pin_pullup_en), .ext_val(ext_val), .ext_en(ext_en), .pin_lvl(pin_lvl));

  // ------
  // helpers
  // ------
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    total_checks++;
    if (got !== ex) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= pbm_pkg::HTRANS_NONSEQ_BIT;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [7:0] dv);
    xfer(1'b1, a, {24'h0, dv});
  endtask : wr
  task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] ex);
    xfer(1'b0, a, 32'h0);
    chk(nm, {24'h0, ex}, rv);
  endtask : rd
  task automatic wt(input int n);
    repeat (n) @(posedge hclk);
  endtask : wt
  task automatic results();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  initial begin
    wt(20000);
    n_errors++;
    results();
  end

  // ------
  // scenarios
  // ------
  initial begin
    void'($urandom(32'h11E78587));
    ext_val <= 8'($urandom);
    wt(5);
    hresetn <= 1'b1;
    for (int i = 0; i < 11; i++) begin
      rd("reset reg", rtab[i][15:8], rtab[i][7:0]);
    end
    chk("reset pullup", 8'h00, pin_pullup_en);
    rd("reset pins", 8'h00, ext_val);
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom);
      l = 8'($urandom);
      v = 8'($urandom);
      m_edge = i[0] ? 8'h7F : 8'hFF;
      en = m_edge[7] ? 8'hFF : 8'($urandom);
      wr(8'h10, m_edge);
      wr(8'h08, d);
      wr(i[1] ? 8'h00 : 8'h04, l);
      ext_val <= v;
      ext_en <= en;
      wt(4);
      chk("pullup", d & {8{~m_edge[7]}}, pin_pullup_en);
      chk("oe", 8'(~d), pin_oe);
      chk("out", l & ~d, pin_out & ~d);
      rd("pins", 8'h00, (l & ~d) | (d & en & v) | (d & ~en));
      rd("latch", 8'h04, l);
    end
    s = 8'($urandom);
    ext_en <= 8'hFF;
    alt_in.lcd_seg_out_30 <= s[0];
    alt_in.lcd_seg_out_8_11 <= s[4:1];
    alt_in.lcd_seg_out_29 <= s[5];
    wr(8'h08, 8'hFF);
    wr(8'h1C, 8'h60);
    wr(8'h18, 8'h0F);
    wt(3);
    chk("seg oe", 8'h3F, pin_oe & 8'h3F);
    chk("seg out", s & 8'h3F, pin_out & 8'h3F);
    rd("seg pins", 8'h00, v & 8'hC0);
    wr(8'h1C, 8'h00);
    wr(8'h18, 8'h00);
    wr(8'h28, 8'h1F);
    wr(8'h0C, 8'h18);
    wr(8'h14, 8'h38);
    for (int j = 0; j < 8; j++) begin
      k = j % 4;
      m_edge = (j < 4) ? 8'hFF : 8'hFF & ~(8'h40 >> k);
      wr(8'h10, m_edge);
      ext_val <= (j < 4) ? 8'h00 : 8'h0F;
      wt(3);
      rd("port", 8'h00, (j < 4) ? 8'h00 : 8'h0F);
      wt(2);
      wr(8'h24, 8'h1F);
      ext_val[k] <= (j < 4);
      wt(4);
      rd("ext flag", 8'h20, 8'h02 << k);
      chk("irq set", 1'b1, irq);
      if (j == 3) begin
        wr(8'h28, 8'h00);
        wt(1);
        chk("irq masked", 1'b0, irq);
        wr(8'h28, 8'h1F);
      end
      wr(8'h24, 8'h02 << k);
      rd("ext clr", 8'h20, 8'h00);
      chk("irq clr", 1'b0, irq);
    end
    wr(8'h10, 8'hFF);
    ext_val <= 8'h00;
    wt(3);
    rd("port", 8'h00, 8'h00);
    wt(2);
    wr(8'h24, 8'h1F);
    ext_val <= 8'h80;
    wt(4);
    rd("chg flag", 8'h0C, 8'h19);
    chk("chg irq", 1'b1, irq);
    chk("chg in", 4'h8, alt_out.change_irq_in);
    wr(8'h24, 8'h01);
    rd("chg held", 8'h20, 8'h01);
    rd("port", 8'h00, 8'h80);
    wt(2);
    wr(8'h24, 8'h01);
    rd("chg clr", 8'h20, 8'h00);
    ext_val <= 8'h00;
    wt(3);
    rd("chg fall", 8'h20, 8'h01);
    rd("port", 8'h00, 8'h00);
    wt(2);
    wr(8'h24, 8'h01);
    wr(8'h04, 8'h50);
    wr(8'h08, 8'h0F);
    wt(4);
    rd("chg out pins", 8'h20, 8'h00);
    wr(8'h04, 8'h00);
    wr(8'h08, 8'hF7);
    wr(8'h2C, 8'h01);
    alt_in.capcomp_out_en <= 1'b1;
    alt_in.capcomp_out <= 1'b1;
    wt(3);
    chk("capcomp", 8'h08, pin_out & pin_oe & 8'h08);
    alt_in.pwm2_chan_a_sel <= 1'b1;
    alt_in.pwm_shutdown <= 1'b1;
    wt(3);
    chk("shutdown", 8'h00, pin_oe & 8'h08);
    alt_in.pwm_shutdown <= 1'b0;
    wt(3);
    chk("no shutdown", 8'h08, pin_oe & 8'h08);
    alt_in.pwm2_chan_a_sel <= 1'b0;
    alt_in.capcomp_out_en <= 1'b0;
    ext_val <= 8'h08;
    wr(8'h08, 8'hFF);
    wt(3);
    chk("capture", 1'b1, alt_out.capcomp_capture_in);
    chk("edge in", 2'h1, {alt_out.edge_in_1, alt_out.edge_in_2});
    wr(8'h08, 8'h00);
    wr(8'h04, 8'h21);
    wt(3);
    chk("fault", 1'b1, alt_out.pwm_fault_in);
    chk("timer", 2'h3, {alt_out.timer3_clk_in, alt_out.timer1_gate_in});
    alt_in.prog_mode <= 1'b1;
    alt_in.prog_serial_dat_oe <= 1'b1;
    alt_in.prog_serial_dat_out <= 1'b1;
    ext_val <= 8'h40;
    wt(3);
    chk("prog pins", 8'h80, pin_out & pin_oe & 8'hC0);
    chk("prog clk", 2'h3, {alt_out.prog_serial_clk, alt_out.prog_serial_dat});
    alt_in.prog_mode <= 1'b0;
    wt(2);
    results();
  end
endmodule : test_port_b_pin_mux

bind pbm_port pbm_port_sva #(.NUM_PINS(NUM_PINS)) i_sva (.hclk(hclk), .hresetn(hresetn),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pin_in(pin_in),
  .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en), .alt_in(alt_in),
  .alt_out(alt_out));
